// ==== rtl/echo_cfg_params.svh ====
// Offsets, field positions, reset values and timing of the canceler config
// Behaviour
// - Address byte register holds memory write address bits 15 to 8.
// - Address byte register holds memory write address bits 7 to 0.
// - Data byte register holds memory write word bits 15 to 8.
// - Data byte register holds memory write word bits 7 to 0.
// - Bits 7:6 set acoustic send output gain: 01,00,11,10 = 18,12,6,0 dB.
// - Bits 5:4 set acoustic send input loss, same code order.
// - Bits 3:2 set line send output gain, same code order.
// - Bits 1:0 set line send input loss, same code order.
// - Pad-bypass pin or control bit bypasses all four level pads.
// - Level fields sampled on frame sync rise; host holds them 250 us.
// - Status bit 7 reads 1 only in initial mode after reset release.
// - Bit 1 picks mu-law or 16-bit linear, ORed with the coding pin.
// - Stall power-down works only with external clock selected.
// - Sync constant for a whole 8 kHz frame counts as stalled.
// - Kind 1: stall sets power-down reset bit; pin or bit releases it.
// - Kind 0: stall mutes; sync rise resets canceler, settles 200 ms.
// - Host loads address and data then sets command; device clears it.
`ifndef ECHO_CFG_PARAMS_SVH
`define ECHO_CFG_PARAMS_SVH

`define ECR_ADDR_HI 4'h0
`define ECR_ADDR_LO 4'h1
`define ECR_DATA_HI 4'h2
`define ECR_DATA_LO 4'h3
`define ECR_LEVELS 4'h4
`define ECR_STATUS 4'h5
`define ECR_MODE 4'h6
`define ECR_MISC 4'h7

`define ECR_RST_BYTE 8'h00
`define ECR_READY_BIT 7
`define ECR_CODING_BIT 1
`define ECR_KIND_BIT 0
`define ECR_PDN_BIT 7
`define ECR_COEF_BIT 6
`define ECR_WCMD_BIT 7
`define ECR_BYP_BIT 2
`define ECR_STATUS_RW 8'h03
`define ECR_MODE_RW 8'h03

`define ECR_CLK_NS 40
`define ECR_CLK_KHZ 25000
`define ECR_FRAME_NS 125000
`define ECR_FRAME_CYC ((`ECR_FRAME_NS + `ECR_CLK_NS - 1) / `ECR_CLK_NS)
`define ECR_SETTLE_MS 200
`define ECR_SETTLE_CYC (`ECR_SETTLE_MS * `ECR_CLK_KHZ)

`endif

// ==== rtl/echo_cfg_pkg.sv ====
// Types shared by the canceler configuration registers
package echo_cfg_pkg;

	typedef enum logic [1:0] {
		PD_RUN = 2'b00,
		PD_MUTE = 2'b01,
		PD_SETTLE = 2'b10,
		PD_RESET = 2'b11
	} pd_state_t;

	// Pad step in units of 6 dB
	typedef logic [1:0] pad_step_t;

endpackage : echo_cfg_pkg

// ==== rtl/echo_canceler_cfg_regs.sv ====
// Configuration registers, pad levels and sync stall power-down control
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "echo_cfg_params.svh"

module echo_canceler_cfg_regs #(
	parameter int SETTLE_CYC = `ECR_SETTLE_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sync,
	input wire logic i_pad_bypass,
	input wire logic i_coding_format_sel,
	input wire logic i_clock_source_sel,
	input wire logic i_powerdown_reset_n,
	input wire logic i_mem_done,
	output logic o_mem_we,
	output logic [15:0] o_mem_addr,
	output logic [15:0] o_mem_data,
	output echo_cfg_pkg::pad_step_t o_acoustic_send_out_step,
	output echo_cfg_pkg::pad_step_t o_acoustic_send_in_step,
	output echo_cfg_pkg::pad_step_t o_line_send_out_step,
	output echo_cfg_pkg::pad_step_t o_line_send_in_step,
	output logic o_mu_law,
	output logic o_mute_powerdown,
	output logic o_powerdown_reset,
	output logic o_settling,
	output logic o_coef_reset
);

	localparam logic [11:0] FRAME_CYC = 12'(`ECR_FRAME_CYC);
	localparam logic [22:0] SETTLE_N = 23'(SETTLE_CYC);

	// Code 01 is the largest pad, 10 the smallest
	function automatic echo_cfg_pkg::pad_step_t pad_step(
		input logic [1:0] code, input logic bypass);
		echo_cfg_pkg::pad_step_t s;
		unique case (code)
			2'b01: s = 2'h3;
			2'b00: s = 2'h2;
			2'b11: s = 2'h1;
			2'b10: s = 2'h0;
		endcase
		return bypass ? 2'h0 : s;
	endfunction : pad_step

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and sync edge

	logic [4:0] pin_s1_q, pin_s1_d;
	logic [4:0] pin_s2_q, pin_s2_d;
	logic sync_prev_q, sync_prev_d;
	logic pdn_pin_prev_q, pdn_pin_prev_d;
	logic sync_edge, sync_rise;
	logic byp_pin, coding_pin, ext_clock, pdn_pin_low, pdn_pin_rel;

	always_comb begin
		pin_s1_d = {i_powerdown_reset_n, i_clock_source_sel,
			i_coding_format_sel, i_pad_bypass, i_sync};
		pin_s2_d = pin_s1_q;
		sync_prev_d = pin_s2_q[0];
		pdn_pin_prev_d = pdn_pin_low;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pin_s1_q <= 5'h10;
			pin_s2_q <= 5'h10;
			sync_prev_q <= 1'b0;
			pdn_pin_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			sync_prev_q <= sync_prev_d;
			pdn_pin_prev_q <= pdn_pin_prev_d;
		end
	end

	assign sync_edge = pin_s2_q[0] ^ sync_prev_q;
	assign sync_rise = pin_s2_q[0] & ~sync_prev_q;
	assign byp_pin = pin_s2_q[1];
	assign coding_pin = pin_s2_q[2];
	assign ext_clock = pin_s2_q[3];
	assign pdn_pin_low = ~pin_s2_q[4];
	assign pdn_pin_rel = pdn_pin_prev_q & ~pdn_pin_low;

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
	logic [7:0] data_hi_q, data_hi_d, data_lo_q, data_lo_d;
	logic [7:0] levels_q, levels_d, status_q, status_d;
	logic [1:0] mode_q, mode_d;
	logic wcmd_q, wcmd_d, byp_bit_q, byp_bit_d;
	logic wr_mode, wr_misc, cfg_clear;
	echo_cfg_pkg::pd_state_t state_q, state_d;

	assign wr_mode = i_wr && i_addr == `ECR_MODE;
	assign wr_misc = i_wr && i_addr == `ECR_MISC;
	// Power-down reset returns every host register to its power-on value
	assign cfg_clear = state_q == echo_cfg_pkg::PD_RESET;

	always_comb begin
		addr_hi_d = addr_hi_q;
		addr_lo_d = addr_lo_q;
		data_hi_d = data_hi_q;
		data_lo_d = data_lo_q;
		levels_d = levels_q;
		status_d = status_q;
		mode_d = mode_q;
		byp_bit_d = byp_bit_q;
		wcmd_d = wcmd_q;
		if (i_wr) begin
			unique case (i_addr)
				`ECR_ADDR_HI: addr_hi_d = i_wdata;
				`ECR_ADDR_LO: addr_lo_d = i_wdata;
				`ECR_DATA_HI: data_hi_d = i_wdata;
				`ECR_DATA_LO: data_lo_d = i_wdata;
				`ECR_LEVELS: levels_d = i_wdata;
				// Reserved bits stay zero whatever is written
				`ECR_STATUS: status_d = i_wdata & `ECR_STATUS_RW;
				`ECR_MODE: mode_d = i_wdata[1:0];
				`ECR_MISC: byp_bit_d = i_wdata[`ECR_BYP_BIT];
				default: ;
			endcase
		end
		// A new command written in the completing cycle survives
		if (i_mem_done)
			wcmd_d = 1'b0;
		if (wr_misc && i_wdata[`ECR_WCMD_BIT])
			wcmd_d = 1'b1;
		if (cfg_clear) begin
			addr_hi_d = `ECR_RST_BYTE;
			addr_lo_d = `ECR_RST_BYTE;
			data_hi_d = `ECR_RST_BYTE;
			data_lo_d = `ECR_RST_BYTE;
			levels_d = `ECR_RST_BYTE;
			status_d = `ECR_RST_BYTE;
			mode_d = 2'h0;
			byp_bit_d = 1'b0;
			wcmd_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			addr_hi_q <= `ECR_RST_BYTE;
			addr_lo_q <= `ECR_RST_BYTE;
			data_hi_q <= `ECR_RST_BYTE;
			data_lo_q <= `ECR_RST_BYTE;
			levels_q <= `ECR_RST_BYTE;
			status_q <= `ECR_RST_BYTE;
			mode_q <= 2'h0;
			byp_bit_q <= 1'b0;
			wcmd_q <= 1'b0;
		end else begin
			addr_hi_q <= addr_hi_d;
			addr_lo_q <= addr_lo_d;
			data_hi_q <= data_hi_d;
			data_lo_q <= data_lo_d;
			levels_q <= levels_d;
			status_q <= status_d;
			mode_q <= mode_d;
			byp_bit_q <= byp_bit_d;
			wcmd_q <= wcmd_d;
		end
	end

	assign o_mem_we = wcmd_q;
	assign o_mem_addr = {addr_hi_q, addr_lo_q};
	assign o_mem_data = {data_hi_q, data_lo_q};

	logic ready;
	assign ready = mode_q == 2'h0 && state_q == echo_cfg_pkg::PD_RUN;

	////////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after the strobe

	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`ECR_ADDR_HI: rdata_d = addr_hi_q;
				`ECR_ADDR_LO: rdata_d = addr_lo_q;
				`ECR_DATA_HI: rdata_d = data_hi_q;
				`ECR_DATA_LO: rdata_d = data_lo_q;
				`ECR_LEVELS: rdata_d = levels_q;
				`ECR_STATUS: begin
					rdata_d = status_q;
					rdata_d[`ECR_READY_BIT] = ready;
				end
				`ECR_MODE: begin
					rdata_d = {6'h00, mode_q};
					rdata_d[`ECR_PDN_BIT] = cfg_clear;
				end
				`ECR_MISC: begin
					rdata_d[`ECR_WCMD_BIT] = wcmd_q;
					rdata_d[`ECR_BYP_BIT] = byp_bit_q;
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign o_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Pad levels, taken only at a frame sync rise

	logic [7:0] lvl_q, lvl_d;
	logic byp_q, byp_d;

	always_comb begin
		lvl_d = lvl_q;
		byp_d = byp_q;
		if (sync_rise) begin
			lvl_d = levels_q;
			byp_d = byp_pin | byp_bit_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			lvl_q <= `ECR_RST_BYTE;
			byp_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
			byp_q <= byp_d;
		end
	end

	assign o_acoustic_send_out_step = pad_step(lvl_q[7:6], byp_q);
	assign o_acoustic_send_in_step = pad_step(lvl_q[5:4], byp_q);
	assign o_line_send_out_step = pad_step(lvl_q[3:2], byp_q);
	assign o_line_send_in_step = pad_step(lvl_q[1:0], byp_q);
	assign o_mu_law = status_q[`ECR_CODING_BIT] | coding_pin;

	////////////////////////////////////////////////////////////////////////
	// Sync stall detection and power-down

	logic [11:0] stall_cnt_q, stall_cnt_d;
	logic [22:0] settle_cnt_q, settle_cnt_d;
	logic coef_q, coef_d, stall_hit, sw_pdn_set, sw_pdn_clr;

	// A frame without any sync transition is a stall
	assign stall_hit = stall_cnt_q >= FRAME_CYC - 12'h1 && !sync_edge
		&& ext_clock;
	assign sw_pdn_set = wr_mode && i_wdata[`ECR_PDN_BIT];
	assign sw_pdn_clr = wr_mode && !i_wdata[`ECR_PDN_BIT];

	always_comb begin
		state_d = state_q;
		settle_cnt_d = settle_cnt_q;
		coef_d = wr_mode && i_wdata[`ECR_COEF_BIT];
		stall_cnt_d = stall_cnt_q;
		// Release must not see a stall left over from before the reset
		if (sync_edge || cfg_clear)
			stall_cnt_d = 12'h000;
		else if (stall_cnt_q < FRAME_CYC)
			stall_cnt_d = stall_cnt_q + 12'h001;
		unique case (state_q)
			echo_cfg_pkg::PD_RUN: begin
				if (stall_hit && status_q[`ECR_KIND_BIT])
					state_d = echo_cfg_pkg::PD_RESET;
				else if (stall_hit)
					state_d = echo_cfg_pkg::PD_MUTE;
			end
			echo_cfg_pkg::PD_MUTE: begin
				if (sync_rise) begin
					state_d = echo_cfg_pkg::PD_SETTLE;
					settle_cnt_d = 23'h000000;
					coef_d = 1'b1;
				end
			end
			echo_cfg_pkg::PD_SETTLE: begin
				settle_cnt_d = settle_cnt_q + 23'h000001;
				if (settle_cnt_q >= SETTLE_N - 23'h000001)
					state_d = echo_cfg_pkg::PD_RUN;
			end
			echo_cfg_pkg::PD_RESET: begin
				// Pin low holds reset; its release or a bit clear frees it
				if (!pdn_pin_low && (pdn_pin_rel || sw_pdn_clr))
					state_d = echo_cfg_pkg::PD_RUN;
			end
		endcase
		if (pdn_pin_low || sw_pdn_set)
			state_d = echo_cfg_pkg::PD_RESET;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= echo_cfg_pkg::PD_RUN;
			stall_cnt_q <= 12'h000;
			settle_cnt_q <= 23'h000000;
			coef_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stall_cnt_q <= stall_cnt_d;
			settle_cnt_q <= settle_cnt_d;
			coef_q <= coef_d;
		end
	end

	assign o_mute_powerdown = state_q == echo_cfg_pkg::PD_MUTE;
	assign o_settling = state_q == echo_cfg_pkg::PD_SETTLE;
	assign o_powerdown_reset = cfg_clear;
	assign o_coef_reset = coef_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_mute_rise;
		state_q == echo_cfg_pkg::PD_MUTE && sync_rise && !pdn_pin_low
			&& !sw_pdn_set;
	endsequence
	sequence s_settle_start;
		o_coef_reset && o_settling && settle_cnt_q == 23'h000000;
	endsequence

	property p_wcmd_clear;
		i_mem_done && !(wr_misc && i_wdata[`ECR_WCMD_BIT]) |=> !o_mem_we;
	endproperty
	a_wcmd_clear: assert property (p_wcmd_clear)
		else $error("write command not cleared after completion");

	property p_wcmd_set;
		wr_misc && i_wdata[`ECR_WCMD_BIT] && !cfg_clear |=> o_mem_we;
	endproperty
	a_wcmd_set: assert property (p_wcmd_set)
		else $error("write command lost");

	property p_level_hold;
		!sync_rise |=> $stable(lvl_q);
	endproperty
	a_level_hold: assert property (p_level_hold)
		else $error("levels changed without a sync rise");

	property p_level_load;
		sync_rise |=> lvl_q == $past(levels_q);
	endproperty
	a_level_load: assert property (p_level_load)
		else $error("levels not taken on sync rise");

	property p_bypass;
		sync_rise && byp_bit_q |=> o_acoustic_send_out_step == 2'h0
			&& o_line_send_in_step == 2'h0;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("pads not bypassed");

	property p_ready;
		i_rd && i_addr == `ECR_STATUS |=> o_rdata[`ECR_READY_BIT]
			== $past(ready);
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready flag wrong");

	property p_internal_clock;
		!ext_clock && state_q == echo_cfg_pkg::PD_RUN |=>
			state_q != echo_cfg_pkg::PD_MUTE;
	endproperty
	a_internal_clock: assert property (p_internal_clock)
		else $error("stall power-down with internal clock");

	property p_stall_reset;
		state_q == echo_cfg_pkg::PD_RUN && stall_hit
			&& status_q[`ECR_KIND_BIT] |=> o_powerdown_reset;
	endproperty
	a_stall_reset: assert property (p_stall_reset)
		else $error("stall did not enter power-down reset");

	property p_stall_mute;
		state_q == echo_cfg_pkg::PD_RUN && stall_hit && !pdn_pin_low
			&& !sw_pdn_set && !status_q[`ECR_KIND_BIT]
			|=> o_mute_powerdown;
	endproperty
	a_stall_mute: assert property (p_stall_mute)
		else $error("stall did not mute");

	property p_resume;
		s_mute_rise |=> s_settle_start;
	endproperty
	a_resume: assert property (p_resume)
		else $error("sync rise did not resume");

endmodule : echo_canceler_cfg_regs
`default_nettype wire

// ==== tb/frame_mem_partner.sv ====
// Frame sync source and internal memory completion model
`timescale 1ns/100ps
`default_nettype none
module frame_mem_partner #(
	parameter int HALF = 1563
) (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_mem_we,
	input wire logic [7:0] i_dly,
	output logic o_sync,
	output logic o_mem_done
);
	int cnt = 0;
	int wait_n = 0;
	logic busy = 1'b0;
	initial o_sync = 1'b0;
	initial o_mem_done = 1'b0;
	// Sync freezes at its level when stopped, which the block sees as a stall
	always @(posedge i_clk) begin
		cnt <= (i_run && cnt < HALF - 1) ? cnt + 1 : 0;
		if (i_run && cnt == HALF - 1) begin
			o_sync <= ~o_sync;
		end
	end
	// One done pulse per command; a new one only after the command drops
	always @(posedge i_clk) begin
		o_mem_done <= 1'b0;
		if (!i_mem_we) begin
			busy <= 1'b0;
			wait_n <= 0;
		end else if (!busy) begin
			wait_n <= wait_n + 1;
			if (wait_n >= int'(i_dly)) begin
				o_mem_done <= 1'b1;
				busy <= 1'b1;
			end
		end
	end
endmodule : frame_mem_partner
`default_nettype wire

// ==== tb/test_echo_canceler_cfg_regs.sv ====
// Self-checking bench for the canceler configuration registers
`timescale 1ns/100ps
`default_nettype none
module test_echo_canceler_cfg_regs;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic byp = 1'b0;
	logic cod = 1'b0;
	logic csel = 1'b0;
	logic pdn_n = 1'b1;
	logic run = 1'b1;
	logic [7:0] dly = 8'h00;
	logic [7:0] rdata;
	logic sync, done, mem_we, mu, mute, pdr, settle, coef;
	logic [15:0] mem_addr, mem_data;
	echo_cfg_pkg::pad_step_t s0, s1, s2, s3;
	int errors = 0;
	int tests_run = 0;
	logic [1:0] codes [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [1:0] steps [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [1:0] prev;
	int n;

	always #20 clk = ~clk;

	echo_canceler_cfg_regs #(.SETTLE_CYC(20)) dut (
		.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sync(sync),
		.i_pad_bypass(byp), .i_coding_format_sel(cod),
		.i_clock_source_sel(csel), .i_powerdown_reset_n(pdn_n),
		.i_mem_done(done), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
		.o_mem_data(mem_data), .o_acoustic_send_out_step(s0),
		.o_acoustic_send_in_step(s1), .o_line_send_out_step(s2),
		.o_line_send_in_step(s3), .o_mu_law(mu), .o_mute_powerdown(mute),
		.o_powerdown_reset(pdr), .o_settling(settle), .o_coef_reset(coef)
	);

	frame_mem_partner partner (
		.i_clk(clk), .i_run(run), .i_mem_we(mem_we), .i_dly(dly),
		.o_sync(sync), .o_mem_done(done)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : chk

	// Lets the edge's updates land before anything is sampled
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask : rd_chk

	task automatic wait_sync;
		logic p;
		p = sync;
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk);
			if (sync && !p) begin
				break;
			end
			p = sync;
		end
		tick(6);
	endtask : wait_sync

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		#(40 * 90000);
		errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd_chk(4'(i), 8'h00);
		end
		rd_chk(4'h5, 8'h80);
		wr_reg(4'h0, 8'h12);
		wr_reg(4'h1, 8'h34);
		wr_reg(4'h2, 8'h56);
		wr_reg(4'h3, 8'h78);
		wr_reg(4'h9, 8'hff);
		rd_chk(4'h0, 8'h12);
		rd_chk(4'h1, 8'h34);
		rd_chk(4'h2, 8'h56);
		rd_chk(4'h3, 8'h78);
		rd_chk(4'h9, 8'h00);
		chk(mem_addr, 16'h1234);
		chk(mem_data, 16'h5678);
		// Slow memory first, then a prompt one right behind it
		for (int i = 0; i < 2; i++) begin
			dly <= (i == 0) ? 8'h14 : 8'h00;
			wr_reg(4'h7, 8'h80);
			chk({15'h0, mem_we}, 16'h0001);
			for (n = 0; n < 100 && mem_we; n++) begin
				tick(1);
			end
			rd_chk(4'h7, 8'h00);
		end
		// Every pad code in every field, taken only at a sync rise
		prev = 2'h2;
		for (int i = 0; i < 4; i++) begin
			wait_sync();
			wr_reg(4'h4, {4{codes[i]}});
			chk({14'h0, s0}, {14'h0, prev});
			wait_sync();
			chk({14'h0, s0}, {14'h0, steps[i]});
			chk({14'h0, s1}, {14'h0, steps[i]});
			chk({14'h0, s2}, {14'h0, steps[i]});
			chk({14'h0, s3}, {14'h0, steps[i]});
			prev = steps[i];
		end
		byp <= 1'b1;
		wr_reg(4'h6, 8'h40);
		chk({15'h0, coef}, 16'h0001);
		wait_sync();
		chk({14'h0, s0}, 16'h0000);
		byp <= 1'b0;
		wr_reg(4'h6, 8'h40);
		wr_reg(4'h7, 8'h04);
		wait_sync();
		chk({14'h0, s3}, 16'h0000);
		wr_reg(4'h7, 8'h00);
		wait_sync();
		chk({14'h0, s3}, 16'h0003);
		// Reserved status bits left clear; ready reads back set
		wr_reg(4'h5, 8'h02);
		rd_chk(4'h5, 8'h82);
		chk({15'h0, mu}, 16'h0001);
		wr_reg(4'h5, 8'h00);
		chk({15'h0, mu}, 16'h0000);
		wr_reg(4'h6, 8'h80);
		wr_reg(4'h6, 8'h00);
		wr_reg(4'h4, 8'h55);
		cod <= 1'b1;
		tick(4);
		chk({15'h0, mu}, 16'h0001);
		cod <= 1'b0;
		// Internal clock mode ignores a frozen sync
		run <= 1'b0;
		tick(3500);
		chk({14'h0, mute, pdr}, 16'h0000);
		csel <= 1'b1;
		tick(3200);
		chk({14'h0, mute, pdr}, 16'h0002);
		run <= 1'b1;
		for (n = 0; n < 4000 && settle !== 1'b1; n++) begin
			tick(1);
		end
		chk({15'h0, coef}, 16'h0001);
		for (n = 0; n < 100 && settle === 1'b1; n++) begin
			tick(1);
		end
		chk({15'h0, n >= 19 && n <= 21}, 16'h0001);
		chk({15'h0, mute}, 16'h0000);
		rd_chk(4'h4, 8'h55);
		// Power-down reset kind clears the registers until released
		wr_reg(4'h5, 8'h01);
		run <= 1'b0;
		tick(3300);
		chk({15'h0, pdr}, 16'h0001);
		rd_chk(4'h5, 8'h00);
		rd_chk(4'h6, 8'h80);
		run <= 1'b1;
		wr_reg(4'h6, 8'h00);
		tick(3);
		chk({15'h0, pdr}, 16'h0000);
		rd_chk(4'h4, 8'h00);
		rd_chk(4'h5, 8'h80);
		pdn_n <= 1'b0;
		tick(4);
		chk({15'h0, pdr}, 16'h0001);
		pdn_n <= 1'b1;
		tick(4);
		chk({15'h0, pdr}, 16'h0000);
		end_sim();
	end
endmodule : test_echo_canceler_cfg_regs
`default_nettype wire
